/* File: src/ptfc_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the timer block
// Assumes: 10 MHz system clock, 12-bit byte address on the register bus
// Notes: Definitions only
`ifndef PTFC_DEFINES_SVH
`define PTFC_DEFINES_SVH

// Register byte offsets
`define PTFC_OFS_TIMER_CONFIG 12'h08c
`define PTFC_OFS_TIMER_COUNT 12'h090
`define PTFC_OFS_FREE_RUN 12'h09c
`define PTFC_OFS_INT_STATUS 12'h050
`define PTFC_OFS_INT_ENABLE 12'h054

// Field positions
`define PTFC_CFG_RUN_BIT 29
`define PTFC_CFG_PRELOAD_MSB 15
`define PTFC_INT_WRAP_BIT 0

// Reset and wrap values
`define PTFC_PRELOAD_RST 16'hffff
`define PTFC_COUNT_RST 16'hffff
`define PTFC_COUNT_WRAP 16'hffff
`define PTFC_COUNT_ZERO 16'h0000
`define PTFC_FRC_RST 32'h0000_0000

// Timing: system clock and timer resolution
`define PTFC_CLK_PERIOD_NS 100
`define PTFC_TICK_PERIOD_US 100
`define PTFC_TICK_CYCLES ((`PTFC_TICK_PERIOD_US * 1000 + `PTFC_CLK_PERIOD_NS - 1) / `PTFC_CLK_PERIOD_NS)

// Timing: free-running counter rate against the system clock
`define PTFC_CLK_RATE_KHZ 10000
`define PTFC_FRC_RATE_KHZ 25000
`define PTFC_FRC_STEP (`PTFC_FRC_RATE_KHZ / `PTFC_CLK_RATE_KHZ)
`define PTFC_FRC_FRAC (`PTFC_FRC_RATE_KHZ % `PTFC_CLK_RATE_KHZ)

// Timing: free-running counter settle bound after reset
`define PTFC_FRC_SETTLE_NS 160
`define PTFC_FRC_SETTLE_CYCLES (`PTFC_FRC_SETTLE_NS / `PTFC_CLK_PERIOD_NS)

`endif

/* File: src/ptfc_pkg.sv */
// Purpose: Types shared by the timer block and its bench
// Assumes: Classic Wishbone, 32-bit data, 12-bit byte address
// Notes: Constants live in ptfc_defines.svh
package ptfc_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [11:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ptfc_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } ptfc_wb_rsp_type;

  typedef enum logic [1:0] {
    PTFC_BUS_IDLE = 2'b01,
    PTFC_BUS_ACK = 2'b10
  } ptfc_bus_state_type;

endpackage

/* File: src/ptfc_prescaler.sv */
// Purpose: Divides the system clock down to the 100 us timer tick
// Assumes: 10 MHz clock, synchronous active-high reset
// Notes: Held at zero while halted and restarted on request
`include "ptfc_defines.svh"

module ptfc_prescaler (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic restart_i,
  // Tick
  output logic tick_o
);

  localparam logic [9:0] LAST = 10'(`PTFC_TICK_CYCLES - 1);

  logic [9:0] count_ff;
  logic tick_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || restart_i) begin
      count_ff <= 10'h000;
    end else if (count_ff == LAST) begin
      count_ff <= 10'h000;
    end else begin
      count_ff <= count_ff + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || restart_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (count_ff == LAST);
    end
  end

  assign tick_o = tick_ff;

endmodule

/* File: src/ptfc_top.sv */
// Purpose: Periodic 16-bit down timer and 32-bit free-running counter behind classic Wishbone
// Assumes: 10 MHz clk_i, synchronous active-high rst_i, single-cycle classic bus master
// Notes: Ack comes one cycle after the request; unmapped reads return zero, writes ignored
`include "ptfc_defines.svh"

module ptfc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire ptfc_pkg::ptfc_wb_req_type wb_req_i,
  output ptfc_pkg::ptfc_wb_rsp_type wb_rsp_o,
  // Host interrupt and status
  output logic irq_o,
  output logic timer_running_o
);

  import ptfc_pkg::*;

  localparam logic [31:0] FRC_STEP = 32'(`PTFC_FRC_STEP);
  localparam logic [13:0] FRC_FRAC = 14'(`PTFC_FRC_FRAC);
  localparam logic [13:0] FRC_MOD = 14'(`PTFC_CLK_RATE_KHZ);

  // Bus handshake state
  ptfc_bus_state_type bus_state_ff;
  ptfc_bus_state_type nxt_bus_state;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // Decoded access
  logic req_new;
  logic wr_commit;
  logic sel_config;
  logic sel_count;
  logic sel_free_run;
  logic sel_int_status;
  logic sel_int_enable;
  logic [31:0] lane_mask;

  // Timer state
  logic run_ff;
  logic nxt_run;
  logic [15:0] preload_ff;
  logic [15:0] nxt_preload;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic run_rise;
  logic run_fall;
  logic preload_written;
  logic tick;
  logic wrap_event;

  // Interrupt state
  logic wrap_flag_ff;
  logic nxt_wrap_flag;
  logic wrap_irq_en_ff;
  logic nxt_wrap_irq_en;
  logic irq_ff;

  // Free-running counter state
  logic [31:0] frc_ff;
  logic [13:0] frc_acc_ff;
  logic [14:0] frc_acc_sum;
  logic frc_carry;

  // Write data merged with current values through byte lanes
  logic [31:0] cfg_now;
  logic [31:0] cfg_merged;
  logic [31:0] ien_merged;

  // Byte enables expanded to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{wb_req_i.sel[lane]}};
    end
  endgenerate

  // Request handshake: ack one cycle after the request, dropped the cycle after
  assign req_new = wb_req_i.cyc && wb_req_i.stb && (bus_state_ff == PTFC_BUS_IDLE);
  assign wr_commit = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && ack_ff;

  always_comb begin
    nxt_bus_state = bus_state_ff;
    case (bus_state_ff)
      PTFC_BUS_IDLE: begin
        if (wb_req_i.cyc && wb_req_i.stb) begin
          nxt_bus_state = PTFC_BUS_ACK;
        end
      end
      PTFC_BUS_ACK: begin
        nxt_bus_state = PTFC_BUS_IDLE;
      end
      default: begin
        nxt_bus_state = PTFC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_ff <= PTFC_BUS_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req_new;
    end
  end

  // Address decode
  always_comb begin
    sel_config = 1'b0;
    sel_count = 1'b0;
    sel_free_run = 1'b0;
    sel_int_status = 1'b0;
    sel_int_enable = 1'b0;
    if (wb_req_i.adr == `PTFC_OFS_TIMER_CONFIG) begin
      sel_config = 1'b1;
    end else if (wb_req_i.adr == `PTFC_OFS_TIMER_COUNT) begin
      sel_count = 1'b1;
    end else if (wb_req_i.adr == `PTFC_OFS_FREE_RUN) begin
      sel_free_run = 1'b1;
    end else if (wb_req_i.adr == `PTFC_OFS_INT_STATUS) begin
      sel_int_status = 1'b1;
    end else if (wb_req_i.adr == `PTFC_OFS_INT_ENABLE) begin
      sel_int_enable = 1'b1;
    end
  end

  // Configuration register view and byte-lane merge
  always_comb begin
    cfg_now = 32'h0000_0000;
    cfg_now[`PTFC_CFG_RUN_BIT] = run_ff;
    cfg_now[`PTFC_CFG_PRELOAD_MSB:0] = preload_ff;
    cfg_merged = (wb_req_i.dat & lane_mask) | (cfg_now & ~lane_mask);
    ien_merged = (wb_req_i.dat & lane_mask) | ({31'h0, wrap_irq_en_ff} & ~lane_mask);
  end

  // Run-enable and preload next values
  always_comb begin
    nxt_run = run_ff;
    nxt_preload = preload_ff;
    preload_written = 1'b0;
    if (wr_commit && sel_config) begin
      nxt_run = cfg_merged[`PTFC_CFG_RUN_BIT];
      nxt_preload = cfg_merged[`PTFC_CFG_PRELOAD_MSB:0];
      preload_written = wb_req_i.sel[0] || wb_req_i.sel[1];
    end
    if (run_ff && !nxt_run) begin
      nxt_preload = `PTFC_PRELOAD_RST;
    end
  end

  assign run_rise = !run_ff && nxt_run;
  assign run_fall = run_ff && !nxt_run;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preload_ff <= `PTFC_PRELOAD_RST;
    end else begin
      preload_ff <= nxt_preload;
    end
  end

  // Tick generator restarts on enable so the first period is whole
  ptfc_prescaler u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_ff),
    .restart_i(run_rise),
    .tick_o(tick)
  );

  // Timer count next value; a load from software wins over a decrement
  always_comb begin
    nxt_count = count_ff;
    wrap_event = 1'b0;
    if (run_ff && tick) begin
      if (count_ff == `PTFC_COUNT_ZERO) begin
        nxt_count = `PTFC_COUNT_WRAP;
        wrap_event = 1'b1;
      end else begin
        nxt_count = count_ff - 16'h0001;
      end
    end
    if (preload_written && !run_fall) begin
      nxt_count = nxt_preload;
    end
    if (run_rise) begin
      nxt_count = nxt_preload;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= `PTFC_COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Wrap flag: a wrap in the same cycle as a clear keeps the flag set
  always_comb begin
    nxt_wrap_flag = wrap_flag_ff;
    if (wr_commit && sel_int_status && wb_req_i.sel[0] && wb_req_i.dat[`PTFC_INT_WRAP_BIT]) begin
      nxt_wrap_flag = 1'b0;
    end
    if (wrap_event) begin
      nxt_wrap_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrap_flag_ff <= 1'b0;
    end else begin
      wrap_flag_ff <= nxt_wrap_flag;
    end
  end

  // Wrap interrupt enable
  always_comb begin
    nxt_wrap_irq_en = wrap_irq_en_ff;
    if (wr_commit && sel_int_enable) begin
      nxt_wrap_irq_en = ien_merged[`PTFC_INT_WRAP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrap_irq_en_ff <= 1'b0;
    end else begin
      wrap_irq_en_ff <= nxt_wrap_irq_en;
    end
  end

  // Host interrupt line follows the gated sticky flag only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_wrap_flag && nxt_wrap_irq_en;
    end
  end

  // Free-running counter: 2.5 counts per system clock, spread by a remainder accumulator
  assign frc_acc_sum = {1'b0, frc_acc_ff} + {1'b0, FRC_FRAC};
  assign frc_carry = (frc_acc_sum >= {1'b0, FRC_MOD});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frc_acc_ff <= 14'h0000;
    end else if (frc_carry) begin
      frc_acc_ff <= 14'(frc_acc_sum - {1'b0, FRC_MOD});
    end else begin
      frc_acc_ff <= frc_acc_sum[13:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frc_ff <= `PTFC_FRC_RST;
    end else begin
      frc_ff <= frc_ff + FRC_STEP + {31'h0, frc_carry};
    end
  end

  // Read data captured when the request is first seen
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (sel_config) begin
      nxt_rdata = cfg_now;
    end else if (sel_count) begin
      nxt_rdata = {16'h0000, count_ff};
    end else if (sel_free_run) begin
      nxt_rdata = frc_ff;
    end else if (sel_int_status) begin
      nxt_rdata = {31'h0, wrap_flag_ff};
    end else if (sel_int_enable) begin
      nxt_rdata = {31'h0, wrap_irq_en_ff};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (req_new) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Outputs
  assign wb_rsp_o.ack = ack_ff;
  assign wb_rsp_o.dat = rdata_ff;
  assign irq_o = irq_ff;
  assign timer_running_o = run_ff;

endmodule

/* File: verification/ptfc_top_sva.sv */
// Purpose: Bus and status relations of the timer block, seen at its ports
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into ptfc_top below
`include "ptfc_defines.svh"

module ptfc_top_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and status
  input wire ptfc_pkg::ptfc_wb_req_type wb_req_i,
  input wire ptfc_pkg::ptfc_wb_rsp_type wb_rsp_o,
  input wire logic irq_o,
  input wire logic timer_running_o
);
  import ptfc_pkg::*;
  logic req;
  logic wr;
  logic wr_cfg;
  logic mapped;
  assign req = wb_req_i.cyc && wb_req_i.stb;
  assign wr = req && wb_req_i.we && wb_rsp_o.ack;
  assign wr_cfg = wr && wb_req_i.adr == `PTFC_OFS_TIMER_CONFIG && wb_req_i.sel[3];
  assign mapped = wb_req_i.adr inside {`PTFC_OFS_TIMER_CONFIG, `PTFC_OFS_TIMER_COUNT,
    `PTFC_OFS_FREE_RUN, `PTFC_OFS_INT_STATUS, `PTFC_OFS_INT_ENABLE};

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_ack_single_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack held for more than one cycle");
  a_ack_one_cycle: assert property (req && !wb_rsp_o.ack |=> wb_rsp_o.ack)
    else $error("request not answered in one cycle");
  a_ack_has_req: assert property ($rose(wb_rsp_o.ack) |-> $past(req))
    else $error("ack without request");
  a_unmapped_reads_zero: assert property (wb_rsp_o.ack && req && !wb_req_i.we && !mapped
    |-> wb_rsp_o.dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_count_upper_zero: assert property (wb_rsp_o.ack && req && !wb_req_i.we
    && wb_req_i.adr == `PTFC_OFS_TIMER_COUNT |-> wb_rsp_o.dat[31:16] == 16'h0000)
    else $error("count wider than 16 bits");
  a_run_rise_cause: assert property ($rose(timer_running_o) |-> $past(wr_cfg && wb_req_i.dat[29]))
    else $error("timer started without enable write");
  a_run_fall_cause: assert property ($fell(timer_running_o) |-> $past(wr_cfg && !wb_req_i.dat[29]))
    else $error("timer stopped without disable write");
  a_irq_fall_cause: assert property ($fell(irq_o) |-> $past(wr && wb_req_i.adr inside
    {`PTFC_OFS_INT_STATUS, `PTFC_OFS_INT_ENABLE}))
    else $error("interrupt dropped without write");
  a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(timer_running_o)
    || $past(wr && wb_req_i.adr == `PTFC_OFS_INT_ENABLE))
    else $error("interrupt raised while timer idle");

  c_run_start: cover property ($rose(timer_running_o));
  c_irq_raise: cover property ($rose(irq_o));
  c_unmapped_read: cover property (wb_rsp_o.ack && req && !wb_req_i.we && !mapped);
endmodule

bind ptfc_top ptfc_top_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_rsp_o(wb_rsp_o), .irq_o(irq_o), .timer_running_o(timer_running_o));

/* File: verification/ptfc_top_test.sv */
// Purpose: Directed bench for the periodic timer and free-running counter
// Assumes: Ack one cycle after take, tick every 1000 cycles
// Notes: Tasks start just after a rising edge
`include "ptfc_defines.svh"

module ptfc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ptfc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ptfc_wb_req_type wb_req_i = '0;
  ptfc_wb_rsp_type wb_rsp_o;
  logic irq_o;
  logic timer_running_o;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] rd;

  ptfc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .irq_o(irq_o), .timer_running_o(timer_running_o));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One classic cycle; waits for ack under a bound
  task bus(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp_o.ack !== 1'b1 && n < 20);
    check({31'h0, wb_rsp_o.ack}, 32'h1);
    rd = wb_rsp_o.dat;
    wb_req_i.cyc <= 1'b0;
    wb_req_i.stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task t_reset_state;
    bus(1'b0, `PTFC_OFS_FREE_RUN, 32'h0);
    check({31'h0, rd < 32'h8}, 32'h1);
    bus(1'b0, `PTFC_OFS_TIMER_CONFIG, 32'h0);
    check(rd, 32'h0000_ffff);
    bus(1'b0, `PTFC_OFS_TIMER_COUNT, 32'h0);
    check(rd, 32'h0000_ffff);
    bus(1'b0, `PTFC_OFS_INT_STATUS, 32'h0);
    check(rd, 32'h0);
    check({30'h0, irq_o, timer_running_o}, 32'h0);
  endtask

  task t_free_rate;
    logic [31:0] a;
    bus(1'b0, `PTFC_OFS_FREE_RUN, 32'h0);
    a = rd;
    repeat (7) @(posedge clk_i);
    bus(1'b0, `PTFC_OFS_FREE_RUN, 32'h0);
    check(rd - a, 32'h19);
  endtask

  task t_map;
    bus(1'b1, 12'h0a0, 32'hffff_ffff);
    bus(1'b0, 12'h0a0, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `PTFC_OFS_TIMER_COUNT, 32'h1234);
    bus(1'b0, `PTFC_OFS_TIMER_COUNT, 32'h0);
    check(rd, 32'h0000_ffff);
    bus(1'b1, `PTFC_OFS_TIMER_CONFIG, 32'h0000_0005);
    bus(1'b0, `PTFC_OFS_TIMER_COUNT, 32'h0);
    check(rd, 32'h0000_0005);
    bus(1'b0, `PTFC_OFS_TIMER_CONFIG, 32'h0);
    check(rd, 32'h0000_0005);
  endtask

  task t_run_wrap;
    bus(1'b1, `PTFC_OFS_TIMER_CONFIG, 32'h2000_0003);
    check({31'h0, timer_running_o}, 32'h1);
    repeat (999) @(posedge clk_i);
    bus(1'b0, `PTFC_OFS_TIMER_COUNT, 32'h0);
    check(rd, 32'h0000_0003);
    bus(1'b0, `PTFC_OFS_TIMER_COUNT, 32'h0);
    check(rd, 32'h0000_0002);
    repeat (2997) @(posedge clk_i);
    bus(1'b0, `PTFC_OFS_TIMER_COUNT, 32'h0);
    check(rd, 32'h0000_ffff);
    bus(1'b0, `PTFC_OFS_INT_STATUS, 32'h0);
    check(rd, 32'h1);
    check({31'h0, irq_o}, 32'h0);
  endtask

  task t_irq_clear;
    bus(1'b1, `PTFC_OFS_INT_ENABLE, 32'h1);
    check({31'h0, irq_o}, 32'h1);
    bus(1'b1, `PTFC_OFS_INT_STATUS, 32'h0);
    check({31'h0, irq_o}, 32'h1);
    bus(1'b1, `PTFC_OFS_INT_STATUS, 32'h1);
    check({31'h0, irq_o}, 32'h0);
  endtask

  task t_halt;
    bus(1'b1, `PTFC_OFS_TIMER_CONFIG, 32'h0000_0007);
    check({31'h0, timer_running_o}, 32'h0);
    bus(1'b0, `PTFC_OFS_TIMER_CONFIG, 32'h0);
    check(rd, 32'h0000_ffff);
    repeat (1100) @(posedge clk_i);
    bus(1'b0, `PTFC_OFS_TIMER_COUNT, 32'h0);
    check(rd, 32'h0000_ffff);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_state();
    t_free_rate();
    t_map();
    t_run_wrap();
    t_irq_clear();
    t_halt();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_state();
    tally_and_finish();
  end

  // Run needs about 5200 cycles
  initial begin
    #2000000;
    check(32'h0, 32'h1);
    tally_and_finish();
  end
endmodule
